// file: design/rsw_pkg.sv
// constants and types shared by the reset supervisor and its release timer
package rsw_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // release delay after supply recovery, in ns (plain default)
  localparam int unsigned RELEASE_DELAY_NS = 10000;
  // least time: round up to whole cycles, never below one
  localparam int unsigned RELEASE_CYCLES_RAW =
    (RELEASE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RELEASE_CYCLES =
    (RELEASE_CYCLES_RAW < 1) ? 1 : RELEASE_CYCLES_RAW;
  localparam int unsigned RELEASE_W = $clog2(RELEASE_CYCLES + 1);

  // ****************************************
  // machine cycle
  // ****************************************
  localparam int unsigned MACH_CLKS = 4;
  localparam logic [1:0] MACH_LAST_PHASE = 2'h3;

  // ****************************************
  // supervision timer
  // ****************************************
  localparam int unsigned COUNT_W = 24;
  localparam int unsigned HIGH_W = 8;
  localparam logic [7:0] KEY_DISARM = 8'h55;
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [23:0] COUNT_MAX = 24'hffffff;
  localparam logic [15:0] LOW_CLEAR = 16'h0000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic pin;
    logic lowSupply;
    logic debug;
    logic watchdog;
  } rsw_cause_s;

  typedef struct packed {
    logic strobe;
    logic [7:0] data;
  } rsw_write_s;

endpackage

// file: design/rsw_release_timer.sv
// holds the low-supply reset for a fixed delay after the supply recovers
`timescale 1ns/10ps
module rsw_release_timer
  import rsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supplyLow,
  output logic holdReset
);

  logic [RELEASE_W-1:0] remain;
  logic [RELEASE_W-1:0] next_remain;

  // ****************************************
  // delay counter
  // ****************************************
  assign next_remain = supplyLow ? RELEASE_W'(RELEASE_CYCLES) :
                       (remain != '0) ? remain - RELEASE_W'(1) : remain;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      remain <= '0;
    end else begin
      remain <= next_remain;
    end
  end

  assign holdReset = supplyLow || (remain != '0);

endmodule

// file: design/rsw_reset_supervisor.sv
// reset merge, power-up flag and supervision timer
`timescale 1ns/10ps
module rsw_reset_supervisor
  import rsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic resetPin_n,
  input wire logic supplyLow,
  input wire logic debugReset,
  input wire logic idleMode,
  input wire logic powerDownMode,
  input wire logic cycleStall,
  input wire rsw_write_s keyWrite,
  input wire rsw_write_s reloadWrite,
  input wire logic powerUpClear,
  output logic coreReset,
  output rsw_cause_s resetCause,
  output logic powerUpFlag,
  output logic timerArmed,
  output logic [23:0] timerCount
);

  // ****************************************
  // declarations
  // ****************************************
  logic supplyHold;
  logic overflowReq;
  logic [7:0] armKey;
  logic [1:0] phase;
  logic machTick;
  logic countRun;
  logic overflowNow;
  logic [7:0] next_armKey;
  logic [23:0] next_timerCount;
  logic [1:0] next_phase;
  logic next_powerUpFlag;
  rsw_cause_s next_resetCause;
  wire logic anyReset;
  wire logic pinReq;
  wire logic debugReq;
  wire logic watchdogReq;
  wire logic keyStrobe;
  wire logic reloadStrobe;
  wire logic atLastPhase;
  wire logic modeHalt;
  wire logic countFull;
  wire logic [23:0] reloadValue;
  wire logic [23:0] countNext;

  // ****************************************
  // helper functions
  // ****************************************
  // key decode: anything but the disarm value arms
  function automatic logic key_arms(input logic [7:0] key);
    key_arms = (key != KEY_DISARM);
  endfunction

  // reload image: written byte on top, low bits cleared
  function automatic logic [23:0] reload_value(input logic [HIGH_W-1:0] high);
    reload_value = {high, LOW_CLEAR};
  endfunction

  // divider step, last phase held while stalled
  function automatic logic [1:0] phase_step(input logic [1:0] cur, input logic hold);
    if (cur == MACH_LAST_PHASE) begin
      phase_step = hold ? cur : 2'h0;
    end else begin
      phase_step = cur + 2'h1;
    end
  endfunction

  // counter step, wraps past all ones
  function automatic logic [23:0] count_step(input logic [23:0] cur);
    count_step = cur + 24'h000001;
  endfunction

  // ****************************************
  // low-supply release delay
  // ****************************************
  rsw_release_timer u_release (
    .mclk(mclk),
    .rst_n(rst_n),
    .supplyLow(supplyLow),
    .holdReset(supplyHold)
  );

  // ****************************************
  // reset sources
  // ****************************************
  assign pinReq = !resetPin_n;
  assign debugReq = debugReset;
  assign watchdogReq = overflowReq;

  // ****************************************
  // reset merge
  // ****************************************
  assign anyReset = pinReq || supplyHold || debugReq || watchdogReq;
  assign next_resetCause = '{pin: pinReq, lowSupply: supplyHold,
                             debug: debugReq, watchdog: watchdogReq};
  assign next_powerUpFlag = supplyLow || (powerUpFlag && !powerUpClear);

  // ****************************************
  // machine cycle divider
  // ****************************************
  assign atLastPhase = (phase == MACH_LAST_PHASE);
  assign machTick = atLastPhase && !cycleStall;
  assign next_phase = phase_step(phase, cycleStall);

  // ****************************************
  // write strobes
  // ****************************************
  assign keyStrobe = keyWrite.strobe;
  assign reloadStrobe = reloadWrite.strobe;
  assign reloadValue = reload_value(reloadWrite.data);

  // ****************************************
  // supervision timer
  // ****************************************
  assign timerArmed = key_arms(armKey);
  assign modeHalt = idleMode || powerDownMode;
  assign countRun = timerArmed && machTick && !modeHalt;
  assign countFull = (timerCount == COUNT_MAX);
  assign countNext = count_step(timerCount);
  assign overflowNow = countRun && countFull && !reloadStrobe;
  assign next_armKey = overflowNow ? KEY_DISARM :
                       keyStrobe ? keyWrite.data : armKey;
  assign next_timerCount = reloadStrobe ? reloadValue :
                           countRun ? countNext : timerCount;

  // ****************************************
  // core reset output
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      coreReset <= 1'b1;
    end else begin
      coreReset <= anyReset;
    end
  end

  // ****************************************
  // reset cause
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      resetCause <= '0;
    end else begin
      resetCause <= next_resetCause;
    end
  end

  // ****************************************
  // power-up flag
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      powerUpFlag <= 1'b0;
    end else begin
      powerUpFlag <= next_powerUpFlag;
    end
  end

  // ****************************************
  // divider phase
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n || anyReset) begin
      phase <= 2'h0;
    end else begin
      phase <= next_phase;
    end
  end

  // ****************************************
  // overflow request
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      overflowReq <= 1'b0;
    end else begin
      overflowReq <= overflowNow;
    end
  end

  // ****************************************
  // arm key register
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n || anyReset) begin
      armKey <= KEY_DISARM;
    end else begin
      armKey <= next_armKey;
    end
  end

  // ****************************************
  // supervision counter
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n || anyReset) begin
      timerCount <= COUNT_RESET;
    end else begin
      timerCount <= next_timerCount;
    end
  end

endmodule

// file: tb/rsw_far_side.sv
// reset switch and supply rail
`timescale 1ns/10ps
module rsw_far_side (
  input wire logic mclk,
  output logic resetPin_n,
  output logic supplyLow
);
  initial begin
    resetPin_n = 1'b1;
    supplyLow = 1'b0;
  end
  task automatic press(input int n);
    @(posedge mclk) resetPin_n <= 1'b0;
    repeat (n) @(posedge mclk);
    resetPin_n <= 1'b1;
  endtask
  task automatic sag(input int n);
    @(posedge mclk) supplyLow <= 1'b1;
    repeat (n) @(posedge mclk);
    supplyLow <= 1'b0;
  endtask
endmodule

// file: tb/rsw_props.sv
// assertions on the reset supervisor ports
`timescale 1ns/10ps
module rsw_props
  import rsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic resetPin_n,
  input wire logic supplyLow,
  input wire logic debugReset,
  input wire logic idleMode,
  input wire logic powerDownMode,
  input wire logic cycleStall,
  input wire rsw_write_s keyWrite,
  input wire rsw_write_s reloadWrite,
  input wire logic powerUpClear,
  input wire logic coreReset,
  input wire rsw_cause_s resetCause,
  input wire logic powerUpFlag,
  input wire logic timerArmed,
  input wire logic [23:0] timerCount
);
  wire quiet = resetPin_n && !supplyLow && !debugReset && !coreReset;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_pin_reset: assert property (!resetPin_n |=> coreReset && resetCause.pin)
    else $error("pin");
  a_supply_hold: assert property ($fell(supplyLow) |=> coreReset [*8])
    else $error("hold");
  a_supply_flag: assert property (supplyLow |=> coreReset && powerUpFlag)
    else $error("flag");
  a_debug_reset: assert property (debugReset |=> coreReset && resetCause.debug)
    else $error("debug");
  a_key_arm: assert property (quiet && keyWrite.strobe |=>
    timerArmed == ($past(keyWrite.data) != KEY_DISARM)) else $error("key");
  a_reload_load: assert property (quiet && reloadWrite.strobe |=>
    timerCount == {$past(reloadWrite.data), LOW_CLEAR}) else $error("reload");
  a_reset_clear: assert property (coreReset |->
    !timerArmed && timerCount == COUNT_RESET) else $error("clear");
  a_idle_stop: assert property (quiet && (idleMode || powerDownMode) &&
    !reloadWrite.strobe |=> $stable(timerCount)) else $error("idle");
  a_count_step: assert property ($changed(timerCount) &&
    $past(quiet && !reloadWrite.strobe) |-> timerCount == $past(timerCount) + 24'h1)
    else $error("step");
endmodule
bind rsw_reset_supervisor rsw_props chk (.*);

// file: tb/testbench.sv
// scenarios for the reset supervisor
`timescale 1ns/10ps
module testbench;
  import rsw_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, debugReset = 1'b0, idleMode = 1'b0, powerDownMode = 1'b0;
  logic powerUpClear = 1'b0, coreReset, powerUpFlag, timerArmed, resetPin_n, supplyLow;
  rsw_write_s keyWrite = '0, reloadWrite = '0;
  rsw_cause_s resetCause;
  logic [23:0] timerCount, c;
  int fail_count = 0, checked = 0, n;
  rsw_far_side far (.mclk(mclk), .resetPin_n(resetPin_n), .supplyLow(supplyLow));
  rsw_reset_supervisor uut (.mclk(mclk), .rst_n(rst_n), .resetPin_n(resetPin_n),
    .supplyLow(supplyLow), .debugReset(debugReset), .idleMode(idleMode),
    .powerDownMode(powerDownMode), .cycleStall(1'b0), .keyWrite(keyWrite),
    .reloadWrite(reloadWrite), .powerUpClear(powerUpClear), .coreReset(coreReset),
    .resetCause(resetCause), .powerUpFlag(powerUpFlag), .timerArmed(timerArmed),
    .timerCount(timerCount));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error %0t mismatch", $time);
    end
  endtask
  task automatic summarize;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic w(input logic r, input logic [7:0] d);
    @(posedge mclk) if (r) reloadWrite <= '{1'b1, d}; else keyWrite <= '{1'b1, d};
    @(posedge mclk) reloadWrite.strobe <= 1'b0;
    keyWrite.strobe <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic dbg;
    @(posedge mclk) debugReset <= 1'b1;
    @(posedge mclk) debugReset <= 1'b0;
    @(negedge mclk) chk(coreReset && resetCause.debug);
    repeat (3) @(negedge mclk);
  endtask
  task automatic t_pin;
    far.press(3);
    @(negedge mclk) chk(coreReset);
    @(negedge mclk) chk(coreReset === 1'b0);
  endtask
  task automatic t_supply;
    @(posedge mclk) powerDownMode <= 1'b1;
    far.sag(2);
    n = 0;
    while (coreReset !== 1'b0 && n < 2100) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 2100) begin
      fail_count++;
      $display("Error %0t supply release timeout", $time);
      return;
    end
    chk(n >= RELEASE_CYCLES && n <= RELEASE_CYCLES + 3);
    chk(powerUpFlag);
    @(posedge mclk) powerDownMode <= 1'b0;
    powerUpClear <= 1'b1;
    @(posedge mclk) powerUpClear <= 1'b0;
    @(negedge mclk) chk(powerUpFlag === 1'b0);
  endtask
  task automatic t_timer;
    w(0, 8'haa);
    chk(timerArmed);
    repeat (40) @(negedge mclk);
    chk(timerCount >= 24'h9 && timerCount <= 24'hb);
    w(1, 8'h04);
    chk(timerCount === 24'h040000);
    @(posedge mclk) idleMode <= 1'b1;
    @(negedge mclk) c = timerCount;
    repeat (20) @(negedge mclk);
    chk(timerCount === c);
    @(posedge mclk) idleMode <= 1'b0;
    w(0, KEY_DISARM);
    chk(timerArmed === 1'b0);
    w(0, 8'h3c);
    dbg();
    chk(timerArmed === 1'b0 && timerCount === COUNT_RESET);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_pin();
    t_supply();
    @(posedge mclk) idleMode <= 1'b1;
    dbg();
    @(posedge mclk) idleMode <= 1'b0;
    t_timer();
    summarize();
  end
endmodule
